// File: hdl/pmbus_telem_map.svh
// Command codes, reset values and timing figures of the PMBus telemetry and limits block.
`ifndef PMBUS_TELEM_MAP_SVH
`define PMBUS_TELEM_MAP_SVH

// ****************************************************************
// Command codes.
// ****************************************************************
`define CMD_OPERATION 8'h01
`define CMD_OT_FAULT 8'h4F
`define CMD_OT_WARN 8'h51
`define CMD_HI_OV_FAULT 8'h55
`define CMD_HI_OV_WARN 8'h57
`define CMD_HI_OC_FAULT 8'h5B
`define CMD_HI_OC_WARN 8'h5D
`define CMD_TON_DELAY 8'h60
`define CMD_READ_HI_V 8'h88
`define CMD_READ_HI_I 8'h89
`define CMD_READ_LO_V 8'h8B
`define CMD_READ_LO_I 8'h8C
`define CMD_READ_TEMP 8'h8D
`define CMD_READ_LO_RES 8'hD4
`define CMD_FAULT_DISABLE 8'hD7

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define OP_ON_BIT 7
`define UV_DISABLE_BIT 0
`define LIMIT_DEFAULT 16'h0064
`define TON_DEFAULT 16'h0000
`define TON_MAX_MS 16'h0064
`define LO_V_DISABLED 16'hF448
`define TEMP_DISABLED 16'hFEEF
`define OVLO_MARGIN_PCT 18'h00003
`define PCT_FULL 18'h00064
`define ADDR_BAND_MSB 11
`define ADDR_BAND_LSB 8

// ****************************************************************
// Timing figures in their own units and derived cycle counts.
// ****************************************************************
`define CLK_MHZ 125
`define T_FAST_REFRESH_US 100
`define T_SLOW_REFRESH_MS 100
`define T_BIAS_ON_US 1500
`define CYC_FAST_REFRESH (`T_FAST_REFRESH_US * `CLK_MHZ)
`define CYC_SLOW_REFRESH (`T_SLOW_REFRESH_MS * 1000 * `CLK_MHZ)
`define CYC_BIAS_ON (`T_BIAS_ON_US * `CLK_MHZ)
`define CYC_PER_MS (1000 * `CLK_MHZ)

`endif

// File: hdl/pmbus_telem_pkg.sv
// Types shared by the PMBus telemetry and limits block.
package pmbus_telem_pkg;

  // Command request as delivered by the SMBus framing layer.
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [15:0] data;
  } pm_req_t;

  // Answer to one request.
  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] data;
  } pm_resp_t;

  // Telemetry refreshed at the fast rate.
  typedef struct packed {
    logic [15:0] hi_v;
    logic [15:0] hi_i;
    logic [15:0] lo_v;
    logic [15:0] lo_i;
  } telem_fast_t;

  // Telemetry refreshed at the slow rate.
  typedef struct packed {
    logic [15:0] lo_res;
    logic [15:0] temp;
  } telem_slow_t;

  // Variable parameters held for the protection logic.
  typedef struct packed {
    logic [15:0] ot_fault;
    logic [15:0] ot_warn;
    logic [15:0] ov_fault;
    logic [15:0] ov_warn;
    logic [15:0] oc_fault;
    logic [15:0] oc_warn;
    logic [15:0] ovlo;
    logic uv_disabled;
    logic [15:0] ton;
  } limits_t;

  // Power stage start sequence.
  typedef enum logic [1:0] {PS_OFF, PS_UV_WAIT, PS_TON, PS_ON} stage_t;

endpackage : pmbus_telem_pkg

// File: hdl/addr_strap.sv
// Address strap capture: decodes the address-select level into a band index once.
`timescale 1ns/10ps
`default_nettype none
`include "pmbus_telem_map.svh"

module addr_strap (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Strap level as a 12-bit code over 0 to 3.3 V, and the capture window.
  input wire logic [11:0] level,
  input wire logic capture,
  // Captured band index.
  output logic [3:0] index,
  output logic valid
);

  // All state of the strap in one record.
  typedef struct packed {
    logic done;
    logic [3:0] idx;
  } strap_t;

  strap_t s_r; // Registered state.
  strap_t s_nxt; // Next state.

  // The first capture wins; later pin changes are ignored until reset.
  always_comb begin
    s_nxt = s_r;
    if (capture && !s_r.done) begin
      s_nxt.done = 1'b1;
      s_nxt.idx = level[`ADDR_BAND_MSB:`ADDR_BAND_LSB]; // RL16 RL17 RL18
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign index = s_r.idx;
  assign valid = s_r.done;

  a_strap_hold: assert property (@(posedge clk_sys) disable iff (reset) s_r.done |=> s_r.done && $stable(s_r.idx)) // RL16
    else $error("address index changed after capture");
  a_strap_band: assert property (@(posedge clk_sys) disable iff (reset)
    capture && !s_r.done |=> s_r.idx == $past(level[11:8])) // RL17
    else $error("address band decoded wrongly");

endmodule : addr_strap
`default_nettype wire

// File: hdl/telem_sampler.sv
// Periodic telemetry latch: holds a snapshot of live readings, refreshed every PERIOD cycles.
`timescale 1ns/10ps
`default_nettype none

module telem_sampler #(
  parameter int W = 64,
  parameter int PERIOD = 12500
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Live readings and the order to forget held values.
  input wire logic [W-1:0] live,
  input wire logic forget,
  // Held readings.
  output logic [W-1:0] held
);

  // The counter is 24 bits wide, so longer periods cannot be served.
  if (PERIOD < 1 || PERIOD > 16777216) begin : g_bad_period
    $error("telem_sampler PERIOD out of range");
  end

  typedef struct packed {
    logic [23:0] cnt;
    logic [W-1:0] val;
  } samp_t;

  samp_t s_r; // Registered state.
  samp_t s_nxt; // Next state.
  logic tick; // Refresh instant.

  // Count the period; losing both supplies wipes the snapshot.
  always_comb begin
    s_nxt = s_r;
    tick = (s_r.cnt == 24'(PERIOD - 1));
    s_nxt.cnt = tick ? 24'h000000 : s_r.cnt + 24'h000001;
    if (forget) begin
      s_nxt.val = '0; // RL14
    end else if (tick) begin
      s_nxt.val = live; // RL1 RL2 RL3
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign held = s_r.val;

  a_sample_tick: assert property (@(posedge clk_sys) disable iff (reset)
    tick && !forget |=> s_r.val == $past(live)) // RL1
    else $error("snapshot not taken at refresh");
  a_hold_between: assert property (@(posedge clk_sys) disable iff (reset)
    !tick && !forget |=> $stable(s_r.val)) // RL2
    else $error("snapshot changed between refreshes");
  a_forget_clear: assert property (@(posedge clk_sys) disable iff (reset) forget |=> s_r.val == '0) // RL14
    else $error("snapshot kept after both supplies were lost");

endmodule : telem_sampler
`default_nettype wire

// File: hdl/pmbus_telemetry_limits.sv
// PMBus command handler: telemetry answers, protection limits, turn-on sequencing.
`timescale 1ns/10ps
`default_nettype none
`include "pmbus_telem_map.svh"

// Notes on behaviour
// RL1 - Voltage reads 88h/8Bh, 0.1 V, 100 us
// RL2 - Current reads 89h/8Ch, 0.01 A, 100 us
// RL3 - Resistance read D4h refreshed every 100 ms
// RL4 - Temperature 8Dh; disabled unit reads -273
// RL5 - Disabled unit reads low-side voltage -300 V
// RL6 - Current readings refused in reverse operation
// RL7 - All limits reset to 100 percent default
// RL8 - Parameter writes only disabled, below UVLO, biased
// RL9 - Host keeps unit disabled 3 ms after writes
// RL10 - Writing 55h sets lockout 3 percent lower
// RL11 - D7h only switches undervoltage to preset default
// RL12 - Turn-on delay follows undervoltage start-up delay
// RL13 - OPERATION and threshold writes need bias present
// RL14 - Telemetry lost when bias and input absent
// RL15 - Interface active 1.5 ms after power arrives
// RL16 - Address sampled once at start-up, then held
// RL17 - Sixteen address bands of 206.25 mV each
// RL18 - Lowest voltage band gives address index zero
// RL19 - SMBus conventions, no alert output provided
module pmbus_telemetry_limits
  import pmbus_telem_pkg::*;
#(
  parameter int FAST_CYC = `CYC_FAST_REFRESH,
  parameter int SLOW_CYC = `CYC_SLOW_REFRESH,
  parameter int BIAS_ON_CYC = `CYC_BIAS_ON,
  parameter int MS_CYC = `CYC_PER_MS,
  parameter logic [6:0] BUS_ADDR_BASE = 7'h40
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Command requests and answers.
  input wire pm_req_t req,
  output pm_resp_t resp,
  // Live telemetry from the converters.
  input wire telem_fast_t fast_live,
  input wire telem_slow_t slow_live,
  // Supply and power stage status.
  input wire logic aux_bias_supply,
  input wire logic hi_present,
  input wire logic hi_below_uvlo,
  input wire logic reverse_flow,
  input wire logic uv_startup_done,
  // Address-select level, 12-bit code over 0 to 3.3 V.
  input wire logic [11:0] addr_level,
  // Status and settings for the protection logic.
  output logic [6:0] bus_addr,
  output logic iface_active,
  output logic stage_on,
  output limits_t limits,
  output logic nvm_commit
);

  // ****************************************************************
  // State record.
  // ****************************************************************

  typedef struct packed {
    logic [23:0] bias_cnt;
    logic active;
    logic op_on;
    stage_t stage;
    logic pwr_on;
    logic [23:0] ms_cnt;
    logic [15:0] ton_ms;
    limits_t lim;
    pm_resp_t resp;
    logic commit;
    logic [6:0] addr;
  } state_t;

  localparam limits_t LIM_INIT = '{
    ot_fault: `LIMIT_DEFAULT, ot_warn: `LIMIT_DEFAULT, ov_fault: `LIMIT_DEFAULT,
    ov_warn: `LIMIT_DEFAULT, oc_fault: `LIMIT_DEFAULT, oc_warn: `LIMIT_DEFAULT,
    ovlo: `LIMIT_DEFAULT, uv_disabled: 1'b0, ton: `TON_DEFAULT};

  state_t s_r; // Registered state.
  state_t s_nxt; // Next state.
  telem_fast_t fast_held; // Fast telemetry snapshot.
  telem_slow_t slow_held; // Slow telemetry snapshot.
  logic [3:0] strap_idx; // Captured address band.
  logic strap_valid; // Address band captured.
  logic take; // A request addressed to us is taken this cycle.
  logic may_write; // Variable parameters may change now.
  logic forget; // Both supplies gone.

  // The counters are 24 bits wide; a 1 ms count must fit as well.
  if (BIAS_ON_CYC < 1 || BIAS_ON_CYC > 16777216 || MS_CYC < 1 || MS_CYC > 16777216) begin : g_bad_count
    $error("pmbus_telemetry_limits count parameter out of range");
  end

  // ****************************************************************
  // Submodules.
  // ****************************************************************

  // Without bias the snapshots only live while the input is present.
  assign forget = !aux_bias_supply && !hi_present;

  telem_sampler #(.W(64), .PERIOD(FAST_CYC)) u_fast (
    .clk_sys(clk_sys),
    .reset(reset),
    .live(fast_live),
    .forget(forget),
    .held(fast_held)
  );

  telem_sampler #(.W(32), .PERIOD(SLOW_CYC)) u_slow (
    .clk_sys(clk_sys),
    .reset(reset),
    .live(slow_live),
    .forget(forget),
    .held(slow_held)
  );

  // The strap is taken when the interface first comes alive.
  addr_strap u_strap (
    .clk_sys(clk_sys),
    .reset(reset),
    .level(addr_level),
    .capture(s_r.active),
    .index(strap_idx),
    .valid(strap_valid)
  );

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Lockout point three percent below the written overvoltage limit.
  function automatic logic [15:0] ovlo_of(input logic [15:0] d);
    logic [17:0] p;
    p = {2'b00, d} * `OVLO_MARGIN_PCT;
    p = p / `PCT_FULL;
    return d - p[15:0];
  endfunction : ovlo_of

  // Requests are honoured only once the interface is up and addressed.
  assign take = req.valid && s_r.active && strap_valid && (req.addr == s_r.addr);
  // Writes need a stopped stage, a low high side and bias present.
  assign may_write = !s_r.op_on && !s_r.pwr_on && hi_below_uvlo && aux_bias_supply; // RL8 RL13

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // Interface wake-up, command decode and stage sequencing.
  always_comb begin
    s_nxt = s_r;
    s_nxt.resp = '0;
    s_nxt.commit = 1'b0;
    s_nxt.addr = BUS_ADDR_BASE + {3'b000, strap_idx};
    // The interface wakes a fixed time after any supply arrives.
    if (!aux_bias_supply && !hi_present) begin
      s_nxt.bias_cnt = 24'h000000;
      s_nxt.active = 1'b0;
    end else if (!s_r.active) begin
      if (s_r.bias_cnt == 24'(BIAS_ON_CYC - 1)) begin
        s_nxt.active = 1'b1; // RL15
      end else begin
        s_nxt.bias_cnt = s_r.bias_cnt + 24'h000001;
      end
    end
    // Every taken request is answered on the next cycle; there is no alert line.
    if (take) begin
      s_nxt.resp.valid = 1'b1; // RL19
      s_nxt.resp.ack = 1'b1;
      if (!req.write) begin
        case (req.cmd)
          `CMD_READ_HI_V: s_nxt.resp.data = fast_held.hi_v; // RL1
          `CMD_READ_LO_V: s_nxt.resp.data = s_r.pwr_on ? fast_held.lo_v : `LO_V_DISABLED; // RL1 RL5
          `CMD_READ_HI_I: begin
            s_nxt.resp.ack = !reverse_flow; // RL6
            s_nxt.resp.data = reverse_flow ? 16'h0000 : fast_held.hi_i; // RL2
          end
          `CMD_READ_LO_I: begin
            s_nxt.resp.ack = !reverse_flow; // RL6
            s_nxt.resp.data = reverse_flow ? 16'h0000 : fast_held.lo_i; // RL2
          end
          `CMD_READ_TEMP: s_nxt.resp.data = s_r.pwr_on ? slow_held.temp : `TEMP_DISABLED; // RL4
          `CMD_READ_LO_RES: s_nxt.resp.data = slow_held.lo_res; // RL3
          `CMD_OT_FAULT: s_nxt.resp.data = s_r.lim.ot_fault;
          `CMD_OT_WARN: s_nxt.resp.data = s_r.lim.ot_warn;
          `CMD_HI_OV_FAULT: s_nxt.resp.data = s_r.lim.ov_fault;
          `CMD_HI_OV_WARN: s_nxt.resp.data = s_r.lim.ov_warn;
          `CMD_HI_OC_FAULT: s_nxt.resp.data = s_r.lim.oc_fault;
          `CMD_HI_OC_WARN: s_nxt.resp.data = s_r.lim.oc_warn;
          `CMD_TON_DELAY: s_nxt.resp.data = s_r.lim.ton;
          `CMD_FAULT_DISABLE: s_nxt.resp.data = {15'h0000, s_r.lim.uv_disabled};
          `CMD_OPERATION: s_nxt.resp.data = {8'h00, s_r.op_on, 7'h00};
          default: s_nxt.resp.ack = 1'b0;
        endcase
      end else begin
        case (req.cmd)
          `CMD_OPERATION: begin
            // Start and stop need bias present.
            s_nxt.resp.ack = aux_bias_supply; // RL13
            if (aux_bias_supply) begin
              s_nxt.op_on = req.data[`OP_ON_BIT]; // RL13
            end
          end
          `CMD_OT_FAULT, `CMD_OT_WARN, `CMD_HI_OV_FAULT, `CMD_HI_OV_WARN,
          `CMD_HI_OC_FAULT, `CMD_HI_OC_WARN: begin
            s_nxt.resp.ack = may_write; // RL8
            s_nxt.commit = may_write;
            if (may_write) begin
              case (req.cmd)
                `CMD_OT_FAULT: s_nxt.lim.ot_fault = req.data;
                `CMD_OT_WARN: s_nxt.lim.ot_warn = req.data;
                `CMD_HI_OV_FAULT: begin
                  s_nxt.lim.ov_fault = req.data;
                  s_nxt.lim.ovlo = ovlo_of(req.data); // RL10
                end
                `CMD_HI_OV_WARN: s_nxt.lim.ov_warn = req.data;
                `CMD_HI_OC_FAULT: s_nxt.lim.oc_fault = req.data;
                default: s_nxt.lim.oc_warn = req.data;
              endcase
            end
          end
          `CMD_TON_DELAY: begin
            // Delays past the top of the range are refused, not clipped.
            s_nxt.resp.ack = may_write && (req.data <= `TON_MAX_MS);
            s_nxt.commit = s_nxt.resp.ack;
            if (s_nxt.resp.ack) begin
              s_nxt.lim.ton = req.data; // RL12
            end
          end
          `CMD_FAULT_DISABLE: begin
            // Only one bit matters: the threshold falls back to its preset.
            s_nxt.resp.ack = may_write;
            s_nxt.commit = may_write;
            if (may_write) begin
              s_nxt.lim.uv_disabled = req.data[`UV_DISABLE_BIT]; // RL11
            end
          end
          default: s_nxt.resp.ack = 1'b0;
        endcase
      end
    end
    // Stage sequencing: the turn-on delay runs after the start-up delay.
    case (s_r.stage)
      PS_OFF: begin
        if (s_r.op_on) begin
          s_nxt.stage = PS_UV_WAIT;
        end
      end
      PS_UV_WAIT: begin
        s_nxt.ms_cnt = 24'h000000;
        s_nxt.ton_ms = 16'h0000;
        if (uv_startup_done) begin
          s_nxt.stage = PS_TON; // RL12
        end
      end
      PS_TON: begin
        if (s_r.ton_ms == s_r.lim.ton) begin
          s_nxt.stage = PS_ON; // RL12
        end else if (s_r.ms_cnt == 24'(MS_CYC - 1)) begin
          s_nxt.ms_cnt = 24'h000000;
          s_nxt.ton_ms = s_r.ton_ms + 16'h0001;
        end else begin
          s_nxt.ms_cnt = s_r.ms_cnt + 24'h000001;
        end
      end
      PS_ON: begin
        if (!uv_startup_done) begin
          s_nxt.stage = PS_UV_WAIT;
        end
      end
      default: s_nxt.stage = PS_OFF;
    endcase
    // A stop order or the loss of both supplies drops the stage at once.
    if (!s_r.op_on || !s_r.active) begin
      s_nxt.stage = PS_OFF;
    end
    s_nxt.pwr_on = (s_nxt.stage == PS_ON);
  end

  // ****************************************************************
  // State register and outputs.
  // ****************************************************************

  // Limits reset to their factory defaults.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r <= '0;
      s_r.lim <= LIM_INIT; // RL7
    end else begin
      s_r <= s_nxt;
    end
  end

  assign resp = s_r.resp;
  assign bus_addr = s_r.addr;
  assign iface_active = s_r.active;
  assign stage_on = s_r.pwr_on;
  assign limits = s_r.lim;
  assign nvm_commit = s_r.commit;

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_lo_v_disabled: assert property (take && !req.write && req.cmd == `CMD_READ_LO_V && !s_r.pwr_on // RL5
    |=> resp.valid && resp.ack && resp.data == `LO_V_DISABLED)
    else $error("disabled low-side voltage read wrong");
  a_temp_disabled: assert property (take && !req.write && req.cmd == `CMD_READ_TEMP && !s_r.pwr_on // RL4
    |=> resp.valid && resp.data == `TEMP_DISABLED)
    else $error("disabled temperature read wrong");
  a_reverse_current: assert property (take && !req.write && reverse_flow // RL6
    && (req.cmd == `CMD_READ_HI_I || req.cmd == `CMD_READ_LO_I) |=> resp.valid && !resp.ack)
    else $error("current read answered in reverse flow");
  a_write_locked: assert property (take && req.write && req.cmd != `CMD_OPERATION && !may_write // RL8
    |=> resp.valid && !resp.ack && $stable(limits) && !nvm_commit)
    else $error("parameter written while locked");
  a_ovlo_auto: assert property (take && req.write && req.cmd == `CMD_HI_OV_FAULT && may_write // RL10
    |=> limits.ov_fault == $past(req.data)
    && 18'(limits.ov_fault - limits.ovlo) == (18'(limits.ov_fault) * 18'h00003) / 18'h00064)
    else $error("lockout point not three percent below limit");
  a_op_bias: assert property (take && req.write && req.cmd == `CMD_OPERATION && !aux_bias_supply // RL13
    |=> $stable(s_r.op_on) && !resp.ack)
    else $error("operation changed without bias");
  a_iface_wake: assert property ($rose(s_r.active) |-> $past(s_r.bias_cnt) == 24'(BIAS_ON_CYC - 1)) // RL15
    else $error("interface woke at wrong time");
  a_ton_done: assert property ($rose(s_r.pwr_on) |-> s_r.ton_ms == s_r.lim.ton && $past(uv_startup_done)) // RL12
    else $error("stage started before turn-on delay");
  a_limit_default: assert property ($past(reset) |-> limits.ot_fault == `LIMIT_DEFAULT // RL7
    && limits.ov_fault == `LIMIT_DEFAULT && limits.ton == `TON_DEFAULT)
    else $error("limits not at defaults after reset");
  a_stop_drops: assert property (!s_r.op_on || !s_r.active |=> !stage_on) // RL12
    else $error("stage still on after stop or supply loss");
  a_commit_ack: assert property (nvm_commit |-> resp.valid && resp.ack) // RL8
    else $error("commit without an accepted write");
  a_refused_zero: assert property (resp.valid && !resp.ack |-> resp.data == 16'h0000) // RL19
    else $error("refused answer carries data");

endmodule : pmbus_telemetry_limits
`default_nettype wire

// File: dv/pm_host.sv
// Host model that frames PMBus commands towards the telemetry and limits block.
`timescale 1ns/10ps
`default_nettype none

module pm_host
  import pmbus_telem_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Request towards the block.
  output pm_req_t req
);
  // ****************************************************************
  // Command framing.
  // ****************************************************************
  // The bus starts idle so that no request can be taken during reset.
  initial begin
    req = '0;
  end

  // One command: launched just after an edge and held across the taking edge.
  // Callers also send parameter writes without bias or with the unit on, to see them refused.
  task automatic send(input logic wr, input logic [7:0] cmd, input logic [15:0] data, input logic [6:0] addr);
    @(posedge clk_sys);
    #1;
    req = '{valid: 1'b1, write: wr, addr: addr, cmd: cmd, data: data};
    @(posedge clk_sys);
    #1;
    req.valid = 1'b0;
    // Released data and command lines flip so a stale word is never mistaken for a live one.
    req.data = ~data;
    req.cmd = ~cmd;
  endtask : send
endmodule : pm_host

`default_nettype wire

// File: dv/pmbus_telemetry_limits_test.sv
// Self-checking bench for the PMBus telemetry and limits block.
`timescale 1ns/10ps
`default_nettype none

module pmbus_telemetry_limits_test import pmbus_telem_pkg::*;;
  // Answer notes: {compare data, commit pulse, ack, data}.
  localparam logic [18:0] WR_OK = 19'h30000;
  localparam logic [18:0] NACK = 19'h40000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  pm_req_t req;
  pm_resp_t resp;
  telem_fast_t fast_live;
  telem_slow_t slow_live;
  logic aux_bias_supply, hi_present, hi_below_uvlo, reverse_flow, uv_startup_done;
  logic [11:0] addr_level;
  logic [6:0] bus_addr, addr_exp;
  logic iface_active, stage_on, nvm_commit;
  limits_t limits;
  int error_cnt = 0;
  int checks = 0;
  logic [18:0] expq[$];
  logic [18:0] e;
  logic [15:0] rnd = 16'hCA6F;
  logic [15:0] d;
  logic [7:0] rd_cmd[6] = '{8'h88, 8'h89, 8'h8B, 8'h8C, 8'h8D, 8'hD4};
  logic [7:0] wr_cmd[6] = '{8'h4F, 8'h51, 8'h55, 8'h57, 8'h5B, 8'h5D};

  // 125 MHz system clock.
  always #4 clk_sys = ~clk_sys;

  // Long counts are shortened so the run stays brief.
  pmbus_telemetry_limits #(.FAST_CYC(20), .SLOW_CYC(50), .BIAS_ON_CYC(10), .MS_CYC(5), .BUS_ADDR_BASE(7'h40))
    u_pmbus_telemetry_limits (.clk_sys(clk_sys), .reset(reset), .req(req), .resp(resp), .fast_live(fast_live),
    .slow_live(slow_live), .aux_bias_supply(aux_bias_supply), .hi_present(hi_present), .hi_below_uvlo(hi_below_uvlo),
    .reverse_flow(reverse_flow), .uv_startup_done(uv_startup_done), .addr_level(addr_level), .bus_addr(bus_addr),
    .iface_active(iface_active), .stage_on(stage_on), .limits(limits), .nvm_commit(nvm_commit));
  pm_host u_pm_host (.clk_sys(clk_sys), .req(req));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Sixteen-bit Fibonacci shift register for stimulus values.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Notes the expected answer, then hands the command to the host.
  task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] dat, input logic [18:0] exp);
    expq.push_back(exp);
    u_pm_host.send(wr, c, dat, addr_exp);
  endtask : cmd

  // Bounded wait for the interface (sel 0) or the power stage (sel 1).
  task automatic wait_flag(input bit sel);
    // Flags are looked at just after the edge, once they have settled.
    for (int i = 0; i < 100 && (sel ? stage_on : iface_active) !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if ((sel ? stage_on : iface_active) !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : wait_flag

  // Answers are settled by the falling edge; each takes the oldest note.
  always @(negedge clk_sys) begin
    if (resp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        check(1, 0);
      end else begin
        e = expq.pop_front();
        check({nvm_commit, resp.ack, e[18] ? resp.data : e[15:0]}, e[17:0]);
      end
    end
  end

  // Global watchdog against a hang anywhere.
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    fast_live = {rnd, lfsr(rnd), ~rnd, 16'h1234};
    slow_live = {lfsr(~rnd), 16'h0019};
    addr_level = rnd[11:0];
    addr_exp = 7'h40 + 7'(rnd[11:8]);
    {aux_bias_supply, hi_present, hi_below_uvlo, reverse_flow, uv_startup_done} = 5'b11100;
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    wait_flag(0);
    repeat (3) @(posedge clk_sys);
    #1 addr_level = ~addr_level;
    repeat (2) @(posedge clk_sys);
    check(bus_addr, addr_exp);
    check(limits[128:17], {7{16'h0064}});
    check(limits[16:0], 17'h00000);
    cmd(0, 8'h8B, 0, {3'b101, 16'hF448});
    cmd(0, 8'h8D, 0, {3'b101, 16'hFEEF});
    rnd = lfsr(rnd);
    d = {4'h0, rnd[11:0]};
    cmd(1, 8'h55, d, WR_OK);
    repeat (2) @(posedge clk_sys);
    check({limits.ov_fault, limits.ovlo}, {d, 16'(d - (d * 3) / 100)});
    foreach (wr_cmd[i]) cmd(1, wr_cmd[i], 16'h0050, WR_OK);
    cmd(1, 8'h59, 16'h0050, NACK);
    cmd(1, 8'hD7, 16'hFF01, WR_OK);
    cmd(1, 8'h60, 16'h0065, NACK);
    cmd(1, 8'h60, 16'h0002, WR_OK);
    repeat (2) @(posedge clk_sys);
    check({limits.uv_disabled, limits.ton}, {1'b1, 16'h0002});
    check(limits[128:17], {{6{16'h0050}}, 16'h004E});
    #1 hi_below_uvlo = 1'b0;
    cmd(1, 8'h57, 16'h0040, NACK);
    {hi_below_uvlo, aux_bias_supply} = 2'b10;
    cmd(1, 8'h57, 16'h0040, NACK);
    cmd(1, 8'h01, 16'h0080, NACK);
    cmd(0, 8'h88, 0, {3'b101, fast_live.hi_v});
    aux_bias_supply = 1'b1;
    repeat (15) @(posedge clk_sys);
    cmd(1, 8'h01, 16'h0080, 19'h10000);
    uv_startup_done = 1'b1;
    repeat (8) @(posedge clk_sys);
    check(stage_on, 1'b0);
    wait_flag(1);
    cmd(1, 8'h57, 16'h0040, NACK);
    foreach (rd_cmd[i]) cmd(0, rd_cmd[i], 0, {3'b101, (i < 4) ? fast_live[63 - 16 * i -: 16] :
      slow_live[31 - 16 * (5 - i) -: 16]});
    reverse_flow = 1'b1;
    cmd(0, 8'h89, 0, NACK);
    cmd(0, 8'h8C, 0, NACK);
    cmd(0, 8'h20, 0, NACK);
    // Losing both supplies puts the interface to sleep; the captured address outlives it.
    {aux_bias_supply, hi_present} = 2'b00;
    repeat (3) @(posedge clk_sys);
    #1 check({iface_active, stage_on}, 2'b00);
    {aux_bias_supply, hi_present} = 2'b11;
    wait_flag(0);
    repeat (3) @(posedge clk_sys);
    check(bus_addr, addr_exp);
    u_pm_host.send(0, 8'h88, 0, addr_exp ^ 7'h01);
    repeat (4) @(posedge clk_sys);
    check(expq.size(), 0);
    tally_and_finish();
  end
endmodule : pmbus_telemetry_limits_test

`default_nettype wire
